/* File: design/adcsq_top.sv */
/*
 * Sequencing control of a 12-bit successive-approximation converter,
 * reproducing its known faulty behaviours.
 * Assumes synchronous control inputs; a timer gives trigger pulses and a
 * DMA controller takes one-cycle completion pulses.
 */
// Notes on behaviour
// RULE1 - Timer trigger without enable toggle halts sampling
// RULE2 - Trigger while busy halts repeat/sequence modes
// RULE3 - Overflow flag unreliable; never set here
// RULE4 - Recovery: clear enable, power; set power, enable
// RULE5 - Controller waits busy clear; slow timer period
// RULE6 - Modes 1,3 pulse DMA every conversion
// RULE7 - DMA uses single transfers, count equals length
// RULE8 - Short extended sample, unbuffered reference corrupts result
// RULE9 - Controller uses buffered reference or longer sample
// RULE10 - Power toggle while busy halts affected modes
// RULE11 - Controller clears enable, waits idle before power
// RULE12 - Source switch off subsystem clock hangs odd dividers
// RULE13 - Hang clears only by system reset
// RULE14 - Controller clears clock-off request or uses even divider
// RULE15 - Busy from sampling start to last conversion end
`timescale 1ns/1ps
`include "adcsq_params.svh"
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int SEQ_W = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic             conversion_enable,
  input  wire logic             converter_power_on,
  input  wire logic             software_start_conversion,
  input  wire logic             timer_trigger,
  input  wire logic             pulse_sample_select,
  input  wire logic [1:0]       sequence_mode_select,
  input  wire logic [3:0]       reference_select,
  input  wire logic [7:0]       sample_time,
  input  wire logic [SEQ_W-1:0] sequence_length,
  input  wire logic [1:0]       converter_clock_source,
  input  wire logic [2:0]       converter_clock_divider,
  input  wire logic             subsystem_clock_off_request,
  output logic                  converter_busy,
  output logic                  dma_trigger,
  output logic                  conversion_done,
  output logic                  result_corrupt,
  output logic                  conversion_timer_overflow_flag,
  output logic                  converter_halted,
  output logic                  converter_hung
);
  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (SEQ_W < 1 || SEQ_W > 8) begin : g_seq_w_check
    $error("adcsq_top: SEQ_W out of range");
  end

  localparam logic [15:0] UNBUF_MASK = `ADCSQ_UNBUF_REF_MASK;

  adcsq_state_t     st_q, st_d;
  logic [7:0]       cnt_q, cnt_d;
  logic [SEQ_W-1:0] idx_q, idx_d;
  logic             armed_q, armed_d;
  logic             en_q, pwr_q, src_q;
  logic [2:0]       div_q;
  logic             bad_q, bad_d;
  logic             busy_d, dma_d, done_d;

  ////////////////////////////////////////////////////////////////////////
  // Converter clock divider

  adcsq_tick_if tk ();
  adcsq_clkdiv u_div (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .tk(tk));

  // Divider counts while powered, stops once hung until system reset
  assign tk.run = converter_power_on && st_q != ADCSQ_HUNG;
  assign tk.div = div_q;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  logic             trig_any;
  logic             enc_rise;
  logic             pwr_toggle;
  logic             mode_seq;
  logic             mode_rep;
  logic             affected;
  logic             odd_div;
  logic             hang_cond;
  logic             unbuf_ref;
  logic             short_bad;
  logic [SEQ_W-1:0] idx_inc;
  logic             last_ch;
  logic [7:0]       samp_len;
  logic             cnt_end;
  logic             start_ok;

  assign trig_any   = software_start_conversion || timer_trigger;
  assign enc_rise   = conversion_enable && !en_q;
  assign pwr_toggle = converter_power_on != pwr_q;
  assign mode_seq   = sequence_mode_select[0];
  assign mode_rep   = sequence_mode_select[1];
  assign affected   = sequence_mode_select != `ADCSQ_MODE_SINGLE;
  // Divider codes 2, 4, 6 are the odd ratios 3, 5, 7
  assign odd_div    = !div_q[0] && (div_q != 3'h0);
  // Switch judged against the previous source sample
  assign hang_cond  = src_q && (converter_clock_source != `ADCSQ_CLKSRC_SUBSYS)
                      && subsystem_clock_off_request && odd_div;        // see RULE12
  assign unbuf_ref  = UNBUF_MASK[reference_select];
  assign short_bad  = !pulse_sample_select && unbuf_ref
                      && (sample_time < `ADCSQ_MIN_EXT_SAMPLE);         // see RULE8
  assign idx_inc    = idx_q + SEQ_W'(1);
  assign last_ch    = !mode_seq || (idx_inc >= sequence_length);
  assign samp_len   = sample_time;
  assign cnt_end    = (cnt_q == 8'h00) && tk.tick;
  assign start_ok   = conversion_enable && converter_power_on && trig_any;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    idx_d   = idx_q;
    armed_d = armed_q || enc_rise;
    bad_d   = bad_q;
    dma_d   = 1'b0;
    done_d  = 1'b0;
    if (cnt_q != 8'h00 && tk.tick) cnt_d = cnt_q - 8'h01;
    unique case (st_q)
      ADCSQ_IDLE: begin
        if (start_ok && timer_trigger && !armed_q) begin
          st_d = ADCSQ_HALT;                                     // see RULE1
        end else if (start_ok) begin
          st_d    = ADCSQ_SAMPLE;                                // see RULE15
          cnt_d   = samp_len;
          idx_d   = '0;
          armed_d = 1'b0;
          bad_d   = short_bad;
        end
      end
      ADCSQ_SAMPLE, ADCSQ_CONV: begin
        if (affected && (trig_any || pwr_toggle)) begin
          st_d = ADCSQ_HALT;                                     // see RULE2, RULE10
        end else if (!converter_power_on) begin
          st_d = ADCSQ_IDLE;
        end else if (cnt_end && st_q == ADCSQ_SAMPLE) begin
          st_d  = ADCSQ_CONV;
          cnt_d = `ADCSQ_CONV_CYCLES;
        end else if (cnt_end) begin
          done_d = 1'b1;
          dma_d  = mode_seq || last_ch;                          // see RULE6
          if (!last_ch) begin
            idx_d = idx_inc;
            st_d  = ADCSQ_SAMPLE;
            cnt_d = samp_len;
          end else if (mode_rep && conversion_enable) begin
            idx_d = '0;
            st_d  = ADCSQ_SAMPLE;
            cnt_d = samp_len;
          end else begin
            st_d = ADCSQ_IDLE;
          end
        end
      end
      ADCSQ_HALT: begin
        if (!conversion_enable && !converter_power_on) st_d = ADCSQ_IDLE;  // see RULE4
      end
      ADCSQ_HUNG: st_d = ADCSQ_HUNG;                             // see RULE13
      default:    st_d = ADCSQ_HUNG;
    endcase
    if (hang_cond) st_d = ADCSQ_HUNG;                            // see RULE12
    busy_d = (st_d == ADCSQ_SAMPLE) || (st_d == ADCSQ_CONV);     // see RULE15
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q    <= ADCSQ_IDLE;
      cnt_q   <= 8'h00;
      idx_q   <= '0;
      armed_q <= 1'b0;
      bad_q   <= 1'b0;
      en_q    <= 1'b0;
      pwr_q   <= 1'b0;
      src_q   <= 1'b0;
      div_q   <= `ADCSQ_RST_DIV;
    end else if (clk_en) begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      idx_q   <= idx_d;
      armed_q <= armed_d;
      bad_q   <= bad_d;
      en_q    <= conversion_enable;
      pwr_q   <= converter_power_on;
      src_q   <= converter_clock_source == `ADCSQ_CLKSRC_SUBSYS;
      div_q   <= converter_clock_divider;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      converter_busy                 <= 1'b0;
      dma_trigger                    <= 1'b0;
      conversion_done                <= 1'b0;
      result_corrupt                 <= 1'b0;
      conversion_timer_overflow_flag <= 1'b0;
      converter_halted               <= 1'b0;
      converter_hung                 <= 1'b0;
    end else if (clk_en) begin
      converter_busy                 <= busy_d;
      dma_trigger                    <= dma_d;
      conversion_done                <= done_d;
      result_corrupt                 <= done_d && bad_q;         // see RULE8
      conversion_timer_overflow_flag <= 1'b0;                    // see RULE3
      converter_halted               <= st_d == ADCSQ_HALT;
      converter_hung                 <= st_d == ADCSQ_HUNG;
    end
  end
endmodule

/* File: design/adcsq_params.svh */
/*
 * Timing counts, field codes and reset values of the converter sequencer.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH

`define ADCSQ_MODE_SINGLE      2'h0
`define ADCSQ_MODE_SEQ         2'h1
`define ADCSQ_MODE_REP_SINGLE  2'h2
`define ADCSQ_MODE_REP_SEQ     2'h3
`define ADCSQ_CLKSRC_SUBSYS    2'h3
`define ADCSQ_MIN_EXT_SAMPLE   8'h06
`define ADCSQ_CONV_CYCLES      8'h0E
`define ADCSQ_UNBUF_REF_MASK   16'h5055
`define ADCSQ_RST_SEQ_LEN      4'h1
`define ADCSQ_RST_DIV          3'h0
`endif

/* File: design/adcsq_pkg.sv */
/*
 * Types of the converter sequencer.
 * Assumes the params header is included by its users.
 */
package adcsq_pkg;
  typedef enum logic [2:0] {
    ADCSQ_IDLE   = 3'b000,
    ADCSQ_SAMPLE = 3'b001,
    ADCSQ_CONV   = 3'b010,
    ADCSQ_HALT   = 3'b011,
    ADCSQ_HUNG   = 3'b100
  } adcsq_state_t;
endpackage

/* File: design/adcsq_tick_if.sv */
/*
 * Carrier between the sequencer and its converter clock divider.
 * Assumes a single clock domain.
 */
`timescale 1ns/1ps
interface adcsq_tick_if;
  logic       run;
  logic [2:0] div;
  logic       tick;
  modport ctl (output run, output div, input tick);
  modport gen (input run, input div, output tick);
endinterface

/* File: design/adcsq_clkdiv.sv */
/*
 * Converter clock divider: one tick every div+1 system cycles.
 * Assumes synchronous reset and a shared clock enable.
 */
`timescale 1ns/1ps
module adcsq_clkdiv (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  adcsq_tick_if.gen tk
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic       wrap;

  assign wrap    = (cnt_q >= tk.div);
  assign cnt_d   = (!tk.run || wrap) ? 3'h0 : cnt_q + 3'h1;
  assign tk.tick = tk.run && wrap;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q <= 3'h0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end
endmodule

/* File: testbench/adcsq_props.sv */
/* Port checker of the converter sequencer.
   Assumes binding into adcsq_top, one clock. */
`timescale 1ns/1ps
`include "adcsq_params.svh"
module adcsq_props (
  input logic       sys_clk,
  input logic       sys_rst,
  input logic       clk_en,
  input logic       conversion_enable,
  input logic       converter_power_on,
  input logic       software_start_conversion,
  input logic       timer_trigger,
  input logic       pulse_sample_select,
  input logic [1:0] sequence_mode_select,
  input logic [3:0] reference_select,
  input logic [7:0] sample_time,
  input logic [1:0] converter_clock_source,
  input logic [2:0] converter_clock_divider,
  input logic       subsystem_clock_off_request,
  input logic       converter_busy,
  input logic       dma_trigger,
  input logic       conversion_done,
  input logic       result_corrupt,
  input logic       conversion_timer_overflow_flag,
  input logic       converter_halted,
  input logic       converter_hung
);
  localparam logic [15:0] UNBUF = `ADCSQ_UNBUF_REF_MASK;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_ovf_zero: assert property (!conversion_timer_overflow_flag)
    else $error("overflow flag set");
  a_dma_each: assert property (conversion_done |-> dma_trigger)
    else $error("done without dma trigger");
  a_corrupt_cause: assert property (result_corrupt |-> conversion_done && !pulse_sample_select
    && UNBUF[reference_select] && sample_time < `ADCSQ_MIN_EXT_SAMPLE) else $error("corrupt without cause");
  a_busy_start: assert property (clk_en && !converter_busy && !converter_halted && !converter_hung
    && conversion_enable && converter_power_on && software_start_conversion |=> converter_busy)
    else $error("busy not raised");
  a_retrig_halt: assert property (clk_en && converter_busy && sequence_mode_select != 2'h0
    && (software_start_conversion || timer_trigger) |-> ##[1:3] converter_halted) else $error("no halt");
  a_power_halt: assert property (clk_en && converter_busy && sequence_mode_select != 2'h0
    && $changed(converter_power_on) |-> ##[0:3] converter_halted) else $error("no halt on power");
  a_hang_entry: assert property (clk_en && $past(converter_clock_source) == 2'h3
    && converter_clock_source != 2'h3 && subsystem_clock_off_request
    && converter_clock_divider inside {3'h2, 3'h4, 3'h6} |-> ##[0:2] converter_hung) else $error("no hang");
  a_hang_sticky: assert property (converter_hung |=> converter_hung)
    else $error("hang left without reset");
  a_halt_sticky: assert property (converter_halted && (conversion_enable || converter_power_on)
    |=> converter_halted) else $error("halt left early");
endmodule
bind adcsq_top adcsq_props u_props (.*);

/* File: testbench/adcsq_partner.sv */
/* Timer trigger source and single-transfer DMA model.
   Assumes the sequencer's clock and reset. */
`timescale 1ns/1ps
module adcsq_partner (
  input  logic       sys_clk,
  input  logic       sys_rst,
  input  logic       fire,
  input  logic       arm,
  input  logic       dma_trigger,
  input  logic [3:0] seq_len,
  output logic       timer_trigger,
  output logic [3:0] dma_count,
  output logic       dma_irq
);
  // Timer pulse only on request, bench keeps the period long
  always @(posedge sys_clk) timer_trigger <= fire && !sys_rst;
  always @(posedge sys_clk) begin
    if (sys_rst || arm) dma_count <= 4'h0;
    else if (dma_trigger) dma_count <= dma_count + 4'h1;
  end
  assign dma_irq = dma_count == seq_len;
endmodule

/* File: testbench/tb_top.sv */
/* Self-checking bench of the converter sequencer.
   Assumes the params header and partner model. */
`timescale 1ns/1ps
`include "adcsq_params.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module tb_top;
  logic sys_clk = 0, sys_rst = 1, clk_en = 1, conversion_enable = 0, converter_power_on = 0, fire = 0;
  logic software_start_conversion = 0, pulse_sample_select = 1, subsystem_clock_off_request = 0, exp_bad = 0;
  logic [1:0] sequence_mode_select = 2'h0, converter_clock_source = 2'h3;
  logic [3:0] reference_select = 4'h0, sequence_length = 4'h1, dma_count;
  logic [7:0] sample_time = 8'h06;
  logic [2:0] converter_clock_divider = 3'h0;
  logic timer_trigger, converter_busy, dma_trigger, conversion_done, result_corrupt, dma_irq;
  logic conversion_timer_overflow_flag, converter_halted, converter_hung;
  int n_fail = 0, n_compared = 0, n_done;
  localparam logic [15:0] UNBUF = `ADCSQ_UNBUF_REF_MASK;
  adcsq_top dut (.sys_clk, .sys_rst, .clk_en, .conversion_enable, .converter_power_on, .software_start_conversion,
    .timer_trigger, .pulse_sample_select, .sequence_mode_select, .reference_select, .sample_time, .sequence_length,
    .converter_clock_source, .converter_clock_divider, .subsystem_clock_off_request, .converter_busy, .dma_trigger,
    .conversion_done, .result_corrupt, .conversion_timer_overflow_flag, .converter_halted, .converter_hung);
  adcsq_partner partner (.sys_clk, .sys_rst, .fire, .arm(software_start_conversion), .dma_trigger,
    .seq_len(sequence_length), .timer_trigger, .dma_count, .dma_irq);
  always #4 sys_clk = ~sys_clk;
  function automatic logic bad();
    return !pulse_sample_select && UNBUF[reference_select] && sample_time < `ADCSQ_MIN_EXT_SAMPLE;
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic conclude;
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic restart;
    @(posedge sys_clk); conversion_enable <= 0; converter_power_on <= 1;
    @(posedge sys_clk); conversion_enable <= 1;
  endtask
  task automatic go(logic tmr);
    @(posedge sys_clk); if (tmr) fire <= 1; else software_start_conversion <= 1;
    @(posedge sys_clk); fire <= 0; software_start_conversion <= 0;
  endtask
  task automatic run(int n);
    n_done = 0;
    for (int k = 0; k < 4000 && n_done < n; k++) begin
      @(posedge sys_clk); #1;
      if (conversion_done === 1'b1) begin
        n_done++;
        `CHK(dma_trigger, 1'b1)
        `CHK(result_corrupt, exp_bad)
        `CHK(conversion_timer_overflow_flag, 1'b0)
      end
    end
    if (n_done < n) begin n_fail++; conclude(); end
  endtask
  task automatic recover;
    @(posedge sys_clk); conversion_enable <= 0; converter_power_on <= 0; sequence_mode_select <= 2'h0;
    pulse_sample_select <= 1;
    restart(); exp_bad = bad(); go(0); run(1);
  endtask
  initial begin
    void'($urandom(32'h1456));
    cyc(6); sys_rst <= 0;
    cyc(1); #1;
    `CHK({converter_busy, converter_halted, converter_hung}, 3'h0)
    for (int i = 0; i < 24; i++) begin
      @(posedge sys_clk); sequence_mode_select <= {1'b0, i[0]}; sequence_length <= 4'($urandom_range(2, 5));
      reference_select <= 4'($urandom); sample_time <= 8'($urandom_range(0, 9));
      pulse_sample_select <= 1'($urandom); converter_clock_divider <= 3'($urandom);
      restart(); exp_bad = bad();
      go(0); run(i[0] ? int'(sequence_length) : 1);
      `CHK(converter_busy, 1'b0)
      cyc(1); #1;
      `CHK(dma_count, i[0] ? sequence_length : 4'h1)
      `CHK(dma_irq, i[0])
    end
    for (int m = 1; m < 6; m++) begin
      @(posedge sys_clk); sequence_mode_select <= 2'(m % 3 + 1);
      restart(); go(0); cyc(5);
      clk_en <= 0; go(0); clk_en <= 1; cyc(1); #1;
      `CHK(converter_halted, 1'b0)
      if (m > 3) begin cyc(1); converter_power_on <= 0; cyc(1); converter_power_on <= 1; end else go(0);
      cyc(3); #1;
      `CHK(converter_halted, 1'b1)
      recover();
    end
    restart(); go(1); run(1);
    go(1); cyc(3); #1;
    `CHK(converter_halted, 1'b1)
    recover();
    for (int d = 0; d < 8; d++) begin
      @(posedge sys_clk); converter_clock_divider <= 3'(d); subsystem_clock_off_request <= 1;
      cyc(2); converter_clock_source <= 2'h1;
      cyc(2); converter_clock_source <= 2'h3; subsystem_clock_off_request <= 0;
      cyc(3); #1;
      `CHK(converter_hung, 1'(d % 2 == 0 && d != 0))
      @(posedge sys_clk); sys_rst <= 1;
      cyc(2); sys_rst <= 0;
      cyc(2); converter_clock_source <= 2'h1;
      cyc(2); converter_clock_source <= 2'h3;
      cyc(2); #1;
      `CHK(converter_hung, 1'b0)
    end
    cyc(2);
    conclude();
  end
endmodule
